/* File: sder_top.sv */
// Purpose: Port 2 rate drop counter, two-slot drop record, interrupt
// Assumes: Drop strobes come from logic on clk, one record per cycle
// Notes: AXI4-Lite slave; register byte address is word index * 4
`timescale 1ns/1ps
`include "sder_defs.svh"

module sder_top
   import sder_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Drop events from the buffer manager
   input  wire logic        p2_rate_drop,
   input  wire logic        drop_valid,
   input  wire logic [1:0]  drop_port,
   input  wire logic [3:0]  drop_reason,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [15:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [15:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Interrupt
   output logic             irq
);

   function automatic logic hit(input logic [15:0] addr,
                                input logic [15:0] idx);
      return addr == {idx[13:0], 2'b00};
   endfunction : hit

   function automatic logic mapped(input logic [15:0] addr);
      return hit(addr, `SDER_IDX_CNT2) || hit(addr, `SDER_IDX_MASK) ||
             hit(addr, `SDER_IDX_PEND) || hit(addr, `SDER_IDX_EVST) ||
             hit(addr, `SDER_IDX_EVEN);
   endfunction : mapped

   function automatic logic rsn_ok(input sder_reason_t r);
      logic ok;
      ok = 1'b0;
      if (r == `SDER_RSN_BC_LVL || r == `SDER_RSN_NO_DEST) begin // R11
         ok = 1'b1;
      end
      if (r == `SDER_RSN_RED || r == `SDER_RSN_YELLOW) begin // R12
         ok = 1'b1;
      end
      if (r == `SDER_RSN_NO_BUF || r == `SDER_RSN_NO_DESC ||
          r == `SDER_RSN_DRP_LVL) begin // R13
         ok = 1'b1;
      end
      if (r == `SDER_RSN_RX_ERR) begin // R14
         ok = 1'b1;
      end
      return ok;
   endfunction : rsn_ok

   // Bus side state
   logic        awready_q;
   logic        wready_q;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [15:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        irq_q;

   // Block state
   logic [31:0] cnt_q;
   logic        mask_q;
   sder_slot_t  slot_a_q;
   sder_slot_t  slot_b_q;
   sder_slot_t  slot_a_d;
   sder_slot_t  slot_b_d;
   logic [3:0]  ev_sts_q;
   logic [3:0]  ev_en_q;
   logic [3:0]  ev_set;
   logic [3:0]  ev_clr;

   logic        wr_go;
   logic        rd_go;
   logic        rd_cnt;
   logic        rd_pend;
   logic        drop_ok;
   logic        byte0_wr;
   logic [31:0] rd_word;
   logic [13:0] pend_word;

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign irq           = irq_q;

   // Write commits only once both halves are held and the response is free
   assign wr_go    = aw_hold_q && w_hold_q && !bvalid_q;
   assign byte0_wr = wr_go && wstrb_q[0];
   assign rd_go    = s_axi_arvalid && arready_q;
   assign rd_cnt   = rd_go && hit(s_axi_araddr, `SDER_IDX_CNT2);
   assign rd_pend  = rd_go && hit(s_axi_araddr, `SDER_IDX_PEND);
   assign drop_ok  = drop_valid && rsn_ok(drop_reason) &&
                     drop_port != `SDER_PORT_RSV; // R8 R14
   assign pend_word = {slot_b_q.rsn, slot_b_q.port, slot_b_q.vld,
                       slot_a_q.rsn, slot_a_q.port, slot_a_q.vld};

   // Write address channel
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q  <= 16'h0000;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         awready_q <= !(s_axi_awvalid && awready_q) &&
                      (!aw_hold_q || wr_go);
      end
   end

   // Write data channel
   always_ff @(posedge clk) begin
      if (rst) begin
         w_hold_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         if (s_axi_wvalid && wready_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
         wready_q <= !(s_axi_wvalid && wready_q) &&
                     (!w_hold_q || wr_go);
      end
   end

   // Write response
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `SDER_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= mapped(awaddr_q) ? `SDER_RESP_OKAY
                                      : `SDER_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit(s_axi_araddr, `SDER_IDX_CNT2)) begin
         rd_word = cnt_q;
      end else if (hit(s_axi_araddr, `SDER_IDX_MASK)) begin
         rd_word = {31'h0000_0000, mask_q};
      end else if (hit(s_axi_araddr, `SDER_IDX_PEND)) begin
         rd_word = {18'h0_0000, pend_word};
      end else if (hit(s_axi_araddr, `SDER_IDX_EVST)) begin
         rd_word = {28'h000_0000, ev_sts_q};
      end else if (hit(s_axi_araddr, `SDER_IDX_EVEN)) begin
         rd_word = {28'h000_0000, ev_en_q};
      end
   end

   // Read channel; data is captured in the same edge as the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `SDER_RESP_OKAY;
      end else begin
         arready_q <= !rd_go && !(rvalid_q && !s_axi_rready);
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word; // R2
            rresp_q  <= mapped(s_axi_araddr) ? `SDER_RESP_OKAY
                                             : `SDER_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Port 2 rate drop counter; a drop in the read cycle starts at one
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= `SDER_CNT_RST;
      end else if (rd_cnt) begin
         cnt_q <= p2_rate_drop ? `SDER_CNT_ONE : `SDER_CNT_RST; // R2
      end else if (p2_rate_drop && cnt_q != `SDER_CNT_MAX) begin // R3
         cnt_q <= cnt_q + `SDER_CNT_ONE; // R1
      end
   end

   // Slot placement; a read clears both slots before the new record lands
   always_comb begin
      slot_a_d = rd_pend ? '0 : slot_a_q; // R7
      slot_b_d = rd_pend ? '0 : slot_b_q; // R10
      ev_set   = 4'h0;
      if (drop_valid && !drop_ok) begin
         ev_set[`SDER_EV_BAD] = 1'b1; // R14
      end
      if (drop_ok) begin
         ev_set[`SDER_EV_REC] = 1'b1;
         if (!slot_a_d.vld) begin // R15
            slot_a_d.vld  = 1'b1; // R6 R7
            slot_a_d.port = drop_port; // R8
            slot_a_d.rsn  = drop_reason; // R9
         end else if (!slot_b_d.vld) begin // R15
            slot_b_d.vld  = 1'b1; // R6 R10
            slot_b_d.port = drop_port;
            slot_b_d.rsn  = drop_reason;
         end else begin
            ev_set[`SDER_EV_LOST] = 1'b1; // R15
         end
      end
      if (p2_rate_drop && !rd_cnt && cnt_q == `SDER_CNT_MAX) begin
         ev_set[`SDER_EV_SAT] = 1'b1;
      end
   end

   // Recording ignores the mask entirely
   always_ff @(posedge clk) begin
      if (rst) begin
         slot_a_q <= '0;
         slot_b_q <= '0;
      end else begin
         slot_a_q <= slot_a_d; // R5
         slot_b_q <= slot_b_d; // R5
      end
   end

   // Mask and event enable registers
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q  <= `SDER_MASK_RST; // R4
         ev_en_q <= `SDER_EV_RST;
      end else if (byte0_wr) begin
         if (hit(awaddr_q, `SDER_IDX_MASK)) begin
            mask_q <= wdata_q[0]; // R4
         end
         if (hit(awaddr_q, `SDER_IDX_EVEN)) begin
            ev_en_q <= wdata_q[3:0];
         end
      end
   end

   // Sticky events, write one to clear; a new event beats the clear
   assign ev_clr = (byte0_wr && hit(awaddr_q, `SDER_IDX_EVST)) ?
                   wdata_q[3:0] : 4'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         ev_sts_q <= `SDER_EV_RST;
      end else begin
         ev_sts_q <= (ev_sts_q & ~ev_clr) | ev_set;
      end
   end

   // One mask bit gates every source, pending slots and sticky events
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= !mask_q && (slot_a_q.vld || slot_b_q.vld ||
                              |(ev_sts_q & ev_en_q)); // R4 R15
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_cnt_incr_one: assert property ( // R1
      p2_rate_drop && !rd_cnt && cnt_q != `SDER_CNT_MAX
      |=> cnt_q == $past(cnt_q) + `SDER_CNT_ONE)
      else $error("counter did not step by one");

   a_cnt_read_clr: assert property ( // R2
      rd_cnt && !p2_rate_drop |=> cnt_q == `SDER_CNT_RST &&
                                  rdata_q == $past(cnt_q))
      else $error("counter read did not return and clear");

   a_cnt_read_drop: assert property ( // R2
      rd_cnt && p2_rate_drop |=> cnt_q == `SDER_CNT_ONE &&
                                 rdata_q == $past(cnt_q))
      else $error("counter read in a drop cycle lost the drop");

   a_cnt_sat_hold: assert property ( // R3
      cnt_q == `SDER_CNT_MAX && !rd_cnt |=> cnt_q == `SDER_CNT_MAX)
      else $error("counter wrapped past maximum");

   a_mask_gate_irq: assert property ( // R4
      mask_q |=> !irq_q)
      else $error("interrupt raised while masked");

   a_mask_keep_sts: assert property ( // R5
      mask_q && drop_ok && !slot_a_q.vld && !rd_pend |=> slot_a_q.vld)
      else $error("mask blocked recording");

   a_fill_slot_a: assert property ( // R6
      drop_ok && !slot_a_q.vld && !rd_pend |=> slot_a_q.vld &&
      slot_a_q.port == $past(drop_port) &&
      slot_a_q.rsn == $past(drop_reason))
      else $error("slot A not filled");

   a_pend_read_clr: assert property ( // R7
      rd_pend && !drop_valid |=> !slot_a_q.vld && !slot_b_q.vld)
      else $error("pending read did not clear slots");

   a_slot_a_port: assert property ( // R8
      slot_a_q.vld |-> slot_a_q.port != `SDER_PORT_RSV)
      else $error("reserved port recorded");

   a_slot_a_rsn: assert property ( // R9
      slot_a_q.vld |-> rsn_ok(slot_a_q.rsn))
      else $error("bad reason in slot A");

   a_fill_slot_b: assert property ( // R10
      drop_ok && slot_a_q.vld && !slot_b_q.vld && !rd_pend
      |=> slot_b_q.vld && $stable(slot_a_q) &&
          slot_b_q.rsn == $past(drop_reason))
      else $error("slot B not filled");

   a_rsv_never_b: assert property ( // R14
      slot_b_q.vld |-> rsn_ok(slot_b_q.rsn) &&
                       slot_b_q.port != `SDER_PORT_RSV)
      else $error("bad record in slot B");

   a_irq_pending: assert property ( // R15
      (slot_a_q.vld || slot_b_q.vld) && !mask_q |=> irq_q)
      else $error("pending record without interrupt");

   a_full_lost: assert property ( // R15
      drop_ok && slot_a_q.vld && slot_b_q.vld && !rd_pend
      |=> $stable(slot_a_q) && $stable(slot_b_q) &&
          ev_sts_q[`SDER_EV_LOST])
      else $error("record into full slots not handled");

   c_two_slots: cover property (slot_a_q.vld && slot_b_q.vld);
   c_cnt_sat:   cover property (cnt_q == `SDER_CNT_MAX);
   c_irq_up:    cover property ($rose(irq_q));
   c_rd_drop:   cover property (rd_pend && drop_ok);

endmodule : sder_top

/* File: sder_defs.svh */
// Purpose: Constants for the switch drop event reporting block
// Assumes: Register indices are word indices; byte address is index * 4
// Notes: Event status and enable indices sit just above the pending word
// Operation
// R1: Each port 2 packet dropped by ingress rate limiting adds one to the counter.
// R2: Reading the port 2 drop counter returns its count and then clears it.
// R3: The port 2 drop counter stops at all ones until it is read.
// R4: Mask bit 0 resets to one and, while set, holds the interrupt low.
// R5: The mask bit never stops recording nor changes recorded status.
// R6: Two independent slots, A and B, hold up to two drop records.
// R7: Slot A valid at bit 0 marks bits 6:1 as a record; read clears all.
// R8: Slot A source port sits in bits 2:1, codes 00, 01, 10; 11 unused.
// R9: Slot A reason sits in bits 6:3 with the same codes as slot B.
// R10: Slot B pending at bit 7 marks reason 13:10 and port 9:8; read clears.
// R11: Reason 0000 is broadcast level exceeded, 0100 no valid destination.
// R12: Reason 0001 is red drop, 1001 is random yellow drop.
// R13: Reason 0010 no buffers, 0011 no descriptors, 0110 drop level hit.
// R14: Reason 0101 is receive error over 64 bytes; other codes never appear.
// R15: A drop fills A, else B, else is lost; irq while a slot is valid.
`ifndef SDER_DEFS_SVH
`define SDER_DEFS_SVH

`define SDER_IDX_CNT2     16'h1c18
`define SDER_IDX_MASK     16'h1c20
`define SDER_IDX_PEND     16'h1c21
`define SDER_IDX_EVST     16'h1c22
`define SDER_IDX_EVEN     16'h1c23

`define SDER_CNT_RST      32'h0000_0000
`define SDER_CNT_ONE      32'h0000_0001
`define SDER_CNT_MAX      32'hffff_ffff
`define SDER_MASK_RST     1'h1
`define SDER_EV_RST       4'h0

`define SDER_RSN_BC_LVL   4'h0
`define SDER_RSN_RED      4'h1
`define SDER_RSN_NO_BUF   4'h2
`define SDER_RSN_NO_DESC  4'h3
`define SDER_RSN_NO_DEST  4'h4
`define SDER_RSN_RX_ERR   4'h5
`define SDER_RSN_DRP_LVL  4'h6
`define SDER_RSN_YELLOW   4'h9
`define SDER_PORT_RSV     2'h3

`define SDER_EV_REC       0
`define SDER_EV_LOST      1
`define SDER_EV_SAT       2
`define SDER_EV_BAD       3

`define SDER_RESP_OKAY    2'h0
`define SDER_RESP_SLVERR  2'h2

`endif

/* File: sder_pkg.sv */
// Purpose: Types for the switch drop event reporting block
// Assumes: Nothing beyond the constants header
// Notes: A slot packs as {reason, port, valid}, as in the pending word
package sder_pkg;
   typedef logic [1:0] sder_port_t;
   typedef logic [3:0] sder_reason_t;
   typedef struct packed {
      sder_reason_t rsn;
      sder_port_t   port;
      logic         vld;
   } sder_slot_t;
endpackage : sder_pkg

/* File: sder_host_model.sv */
// Purpose: Host software model on the AXI4-Lite register bus
// Assumes: One write and one read at most under way at a time
// Notes: Response ready stays high, so an answer is never stalled
`timescale 1ns/1ps

module sder_host_model (
   // Clock
   input  wire logic        clk,
   // Write channels
   output logic             awvalid,
   input  wire logic        awready,
   output logic [15:0]      awaddr,
   output logic             wvalid,
   input  wire logic        wready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   input  wire logic        bvalid,
   output logic             bready,
   input  wire logic [1:0]  bresp,
   // Read channels
   output logic             arvalid,
   input  wire logic        arready,
   output logic [15:0]      araddr,
   input  wire logic        rvalid,
   output logic             rready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   initial begin
      awvalid = 1'b0;
      wvalid  = 1'b0;
      arvalid = 1'b0;
      awaddr  = 16'h0000;
      araddr  = 16'h0000;
      wdata   = 32'h0000_0000;
      wstrb   = 4'hf;
      bready  = 1'b1;
      rready  = 1'b1;
   end

   // Address and data are released each on its own handshake
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      r = bresp;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : rd
endmodule : sder_host_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the drop event reporting block
// Assumes: Host model owns the register bus; bench drives drop strobes
// Notes: Counter saturation needs 2^32 drops and is left to assertions
`timescale 1ns/1ps
`include "sder_defs.svh"

module testbench
   import sder_pkg::*;
;
   logic        clk, rst, p2_rate_drop, drop_valid, irq;
   logic [1:0]  drop_port, bresp, rresp, r, pa, pb;
   logic [3:0]  drop_reason, wstrb, rb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, v;
   int          n_mismatch, cmp_count, seed, i, k, n;
   localparam logic [3:0] RSN [8] = '{`SDER_RSN_BC_LVL, `SDER_RSN_RED,
      `SDER_RSN_NO_BUF, `SDER_RSN_NO_DESC, `SDER_RSN_NO_DEST,
      `SDER_RSN_RX_ERR, `SDER_RSN_DRP_LVL, `SDER_RSN_YELLOW};

   sder_top sder_top_i (.clk(clk), .rst(rst),
      .p2_rate_drop(p2_rate_drop), .drop_valid(drop_valid),
      .drop_port(drop_port), .drop_reason(drop_reason),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .irq(irq));

   sder_host_model sder_host_model_i (.clk(clk), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   function automatic logic [15:0] ba(input logic [15:0] idx);
      ba = idx << 2;
   endfunction : ba

   // Pending word as software sees it: slot B above slot A
   function automatic logic [31:0] pw(input sder_slot_t a, sder_slot_t b);
      pw = {18'h0, b, a};
   endfunction : pw

   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_w

   task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_r

   task automatic chk_b(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_b

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic send(input logic [1:0] p, input logic [3:0] c);
      drop_valid  <= 1'b1;
      drop_port   <= p;
      drop_reason <= c;
      @(posedge clk);
      drop_valid  <= 1'b0;
      @(posedge clk);
   endtask : send

   task automatic settle;
      repeat (2) @(posedge clk);
   endtask : settle

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      seed = 32'h4600;
      rst = 1'b1;
      p2_rate_drop = 1'b0;
      drop_valid = 1'b0;
      drop_port = 2'h0;
      drop_reason = 4'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      sder_host_model_i.rd(ba(`SDER_IDX_MASK), d, r);
      chk_w(d, 32'h0000_0001);
      sder_host_model_i.rd(ba(`SDER_IDX_CNT2), d, r);
      chk_w(d, `SDER_CNT_RST);
      sder_host_model_i.rd(ba(`SDER_IDX_PEND), d, r);
      chk_w(d, 32'h0000_0000);
      chk_b(irq, 1'b0);
      // Random drop strobes, first round back to back
      for (k = 0; k < 4; k++) begin
         n = 0;
         repeat (40) begin
            v = $random(seed);
            v[0] = v[0] | (k == 0);
            p2_rate_drop <= v[0];
            n += v[0];
            @(posedge clk);
         end
         p2_rate_drop <= 1'b0;
         @(posedge clk);
         sder_host_model_i.rd(ba(`SDER_IDX_CNT2), d, r);
         chk_w(d, 32'(n));
         sder_host_model_i.rd(ba(`SDER_IDX_CNT2), d, r);
         chk_w(d, `SDER_CNT_RST);
      end
      // Drop in the read cycle counts after the clear
      p2_rate_drop <= 1'b1;
      sder_host_model_i.rd(ba(`SDER_IDX_CNT2), d, r);
      p2_rate_drop <= 1'b0;
      chk_w(d, `SDER_CNT_RST);
      sder_host_model_i.rd(ba(`SDER_IDX_CNT2), d, r);
      chk_w(d, 32'h0000_0002);
      // Three records: A, B, then one that finds both slots full
      for (i = 0; i < 8; i++) begin
         pa = 2'($unsigned($random(seed)) % 3);
         pb = 2'($unsigned($random(seed)) % 3);
         rb = RSN[(i + 1) % 8];
         send(pa, RSN[i]);
         send(pb, rb);
         send(pb, RSN[7 - i]);
         v = $random(seed);
         v[0] = i[0];
         sder_host_model_i.wr(ba(`SDER_IDX_MASK), v, r);
         chk_r(r, `SDER_RESP_OKAY);
         sder_host_model_i.rd(ba(`SDER_IDX_MASK), d, r);
         chk_w(d, {31'h0, v[0]});
         settle();
         chk_b(irq, ~v[0]);
         sder_host_model_i.rd(ba(`SDER_IDX_PEND), d, r);
         chk_w(d, pw({RSN[i], pa, 1'b1}, {rb, pb, 1'b1}));
         settle();
         chk_b(irq, 1'b0);
      end
      // Reserved reasons and reserved port are never recorded
      for (k = 7; k < 16; k++)
         if (k != 9)
            send(2'h0, 4'(k));
      send(`SDER_PORT_RSV, `SDER_RSN_RED);
      sder_host_model_i.rd(ba(`SDER_IDX_PEND), d, r);
      chk_w(d, 32'h0000_0000);
      // Record in the clearing read lands in A, the next one in B
      drop_valid  <= 1'b1;
      drop_port   <= 2'h2;
      drop_reason <= `SDER_RSN_YELLOW;
      sder_host_model_i.rd(ba(`SDER_IDX_PEND), d, r);
      drop_valid  <= 1'b0;
      chk_w(d, 32'h0000_0000);
      sder_host_model_i.rd(ba(`SDER_IDX_PEND), d, r);
      chk_w(d, pw({`SDER_RSN_YELLOW, 2'h2, 1'b1},
                  {`SDER_RSN_YELLOW, 2'h2, 1'b1}));
      // Accepted, lost and rejected records all left their marks
      sder_host_model_i.rd(ba(`SDER_IDX_EVST), d, r);
      chk_w(d, 32'h0000_000b);
      // Rejected-record event: raise, clear, raise, mask
      sder_host_model_i.wr(ba(`SDER_IDX_EVEN), 32'h0000_0008, r);
      sder_host_model_i.wr(ba(`SDER_IDX_MASK), 32'h0000_0000, r);
      settle();
      chk_b(irq, 1'b1);
      sder_host_model_i.wr(ba(`SDER_IDX_EVST), 32'h0000_000f, r);
      settle();
      chk_b(irq, 1'b0);
      send(2'h1, 4'h7);
      settle();
      chk_b(irq, 1'b1);
      sder_host_model_i.wr(ba(`SDER_IDX_MASK), 32'h0000_0001, r);
      settle();
      chk_b(irq, 1'b0);
      // Unmapped place in the register map
      sder_host_model_i.rd(16'h7090, d, r);
      chk_w(d, 32'h0000_0000);
      chk_r(r, `SDER_RESP_SLVERR);
      sder_host_model_i.wr(16'h7094, 32'h0000_0001, r);
      chk_r(r, `SDER_RESP_SLVERR);
      conclude();
   end
endmodule : testbench
